/* File: isl_pkg.sv */
// shared constants, types and decode helpers of the two-wire slave port
package isl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // addressing
    localparam logic [6:0] OWN7_BASE = 7'h42;
    localparam logic [4:0] TEN_PREFIX = 5'h1e;
    // arbitrary value: upper bits of the own 10-bit address
    localparam logic [1:0] TEN_HI_DEF = 2'h0;
    // arbitrary value: low byte base of the own 10-bit address
    localparam logic [7:0] TEN_LO_DEF = 8'h84;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET_CODE = 8'h06;
    localparam logic [7:0] GC_LATCH_CODE = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // timing and reset values
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [7:0] REG_ADDR_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        K_WRITE = 2'h0,
        K_READ = 2'h1,
        K_LATCH = 2'h2,
        K_RESET = 2'h3
    } isl_kind_t;

    typedef struct packed {
        isl_kind_t kind;
        logic [7:0] addr;
        logic [7:0] data;
    } isl_req_t;

    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [7:0] data;
    } isl_regport_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR2 = 3'h3,
        ST_REG = 3'h2,
        ST_WDATA = 3'h6,
        ST_RDATA = 3'h7,
        ST_GC = 3'h5,
        ST_IGNORE = 3'h4
    } isl_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // register address ranges that advance after each byte
    function automatic logic islAutoInc(input logic [7:0] a);
        logic inc;
        inc = (a <= 8'h07) || (a >= 8'h10 && a <= 8'h1f) ||
              (a >= 8'h30 && a <= 8'h37) || (a >= 8'h60 && a <= 8'h77) ||
              (a >= 8'h80 && a <= 8'hbf);
        return inc;
    endfunction : islAutoInc

endpackage : isl_pkg

/* File: isl_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module isl_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t r;
    sync_t n;

    always_comb
    begin
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule : isl_sync2

/* File: isl_hs_cross.sv */
// toggle handshake carrying a request word one way and an answer word back
`timescale 1ns/100ps
module isl_hs_cross #(
    parameter int W_REQ = 8,
    parameter int W_RSP = 8
) (
    input wire logic rst_n,
    input wire logic srcClk,
    input wire logic srcReq,
    input wire logic [W_REQ-1:0] srcData,
    output logic srcBusy,
    output logic srcDone,
    output logic [W_RSP-1:0] srcRsp,
    input wire logic dstClk,
    output logic dstValid,
    output logic [W_REQ-1:0] dstData,
    input wire logic dstAck,
    input wire logic [W_RSP-1:0] dstRsp
);
    typedef struct packed {
        logic reqTgl;
        logic [W_REQ-1:0] data;
        logic ackSeen;
        logic [W_RSP-1:0] rsp;
        logic done;
    } src_t;

    typedef struct packed {
        logic reqSeen;
        logic valid;
        logic [W_REQ-1:0] data;
        logic ackTgl;
        logic [W_RSP-1:0] rsp;
    } dst_t;

    src_t sr;
    src_t sn;
    dst_t dr;
    dst_t dn;
    logic ackS;
    logic reqS;

    isl_sync2 #(.W(1)) uAckSync (
        .clk(srcClk),
        .rst_n(rst_n),
        .d(dr.ackTgl),
        .q(ackS)
    );

    isl_sync2 #(.W(1)) uReqSync (
        .clk(dstClk),
        .rst_n(rst_n),
        .d(sr.reqTgl),
        .q(reqS)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source side: words stay frozen while the toggle travels
    always_comb
    begin
        sn = sr;
        sn.done = 1'b0;
        if (srcReq && (sr.reqTgl == sr.ackSeen))
        begin
            sn.reqTgl = ~sr.reqTgl;
            sn.data = srcData;
        end
        if (ackS != sr.ackSeen)
        begin
            sn.ackSeen = ackS;
            sn.rsp = dr.rsp;
            sn.done = 1'b1;
        end
    end

    always_ff @(posedge srcClk or negedge rst_n)
    begin
        if (!rst_n)
            sr <= '0;
        else
            sr <= sn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // destination side
    always_comb
    begin
        dn = dr;
        dn.valid = 1'b0;
        if (reqS != dr.reqSeen)
        begin
            dn.reqSeen = reqS;
            dn.valid = 1'b1;
            dn.data = sr.data;
        end
        if (dstAck)
        begin
            dn.ackTgl = ~dr.ackTgl;
            dn.rsp = dstRsp;
        end
    end

    always_ff @(posedge dstClk or negedge rst_n)
    begin
        if (!rst_n)
            dr <= '0;
        else
            dr <= dn;
    end

    assign srcBusy = sr.reqTgl != sr.ackSeen;
    assign srcDone = sr.done;
    assign srcRsp = sr.rsp;
    assign dstValid = dr.valid;
    assign dstData = dr.data;
endmodule : isl_hs_cross

/* File: isl_slave.sv */
// two-wire slave port giving a host access to 8-bit internal registers
//
// Operation
// RL1 - 8-bit registers, each module within its own range
// RL2 - address advances per byte in incrementing ranges
// RL3 - address holds across bytes in 0x38 to 0x3f
// RL4 - slave only, standard 100 kbps and fast 400 kbps rates
// RL5 - accepts 7-bit and 10-bit addressing plus general call
// RL6 - select pins sampled at reset, free afterwards
// RL7 - low bits latched once, pins re-read on general call
// RL8 - start is data falling while clock high
// RL9 - all activity ignored until a start is seen
// RL10 - master sends start then slave address before any transfer
// RL11 - stop is data rising while clock high; ends transfer
// RL12 - no-ack then stop returns slave to idle
// RL13 - stop after a write ends register writing
// RL14 - sender releases data after eight bits, receiver acks ninth
// RL15 - no-ack leaves data high on ninth clock
// RL16 - data sampled on each rising clock edge
// RL17 - master changes data only while clock low
// RL18 - select pins 00,01,10,11 give address bytes 0x84,0x86,0x88,0x8a
// RL19 - bit after address: 1 reads, 0 writes
// RL20 - matching address is acknowledged on the ninth bit
// RL21 - no match: no ack and off the bus for the transaction
// RL22 - read: address write, register, restart, address read, data, stop
// RL23 - write: address write, register, data bytes, stop
// RL24 - general call ack; 0x06 resets and latches, 0x04 only latches
// RL25 - bytes travel most significant bit first
`timescale 1ns/100ps
module isl_slave #(
    parameter logic [1:0] TEN_HI_BITS = isl_pkg::TEN_HI_DEF,
    parameter logic [7:0] TEN_LO_BASE = isl_pkg::TEN_LO_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic linkSampleClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrSelPinLow,
    input wire logic addrSelPinHigh,
    output isl_pkg::isl_regport_t regPort,
    input wire logic [7:0] regRdData,
    output logic gcSoftReset,
    output logic [1:0] slaveAddrSel
);
    import isl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state of both domains
    typedef struct packed {
        isl_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] rdByte;
        logic [7:0] regAddr;
        logic tenOk;
        logic slvAck;
        logic sclD;
        logic sdaD;
        logic sdaOe;
        logic sdaO;
        logic reqStb;
        isl_req_t req;
    } lnk_t;

    typedef struct packed {
        isl_regport_t port;
        logic [7:0] rsp;
        logic ack;
        logic rdWait;
        logic softRst;
        logic [1:0] sel;
        logic [1:0] settle;
        logic strapDone;
    } ref_t;

    lnk_t lr, ln;
    ref_t rr, rn;
    logic scl, sda, srcBusy, srcDone, dstValid;
    logic sclRise, sclFall, startCond, stopCond;
    logic [1:0] linkSel, pinSel;
    logic [7:0] srcRsp, tenLo;
    isl_req_t dstReq;
    logic [6:0] own7;

    ////////////////////////////////////////////////////////////////////////////
    // crossings
    isl_sync2 #(.W(4)) uLinkSync (
        .clk(linkSampleClk),
        .rst_n(nrst),
        .d({sclIn, sdaIn, rr.sel}),
        .q({scl, sda, linkSel})
    );

    isl_sync2 #(.W(2)) uPinSync (
        .clk(ref_clk),
        .rst_n(nrst),
        .d({addrSelPinHigh, addrSelPinLow}),
        .q(pinSel)
    );

    isl_hs_cross #(.W_REQ($bits(isl_req_t)), .W_RSP(8)) uCross (
        .rst_n(nrst),
        .srcClk(linkSampleClk),
        .srcReq(lr.reqStb),
        .srcData(lr.req),
        .srcBusy(srcBusy),
        .srcDone(srcDone),
        .srcRsp(srcRsp),
        .dstClk(ref_clk),
        .dstValid(dstValid),
        .dstData(dstReq),
        .dstAck(rr.ack),
        .dstRsp(rr.rsp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus conditions on the synchronised lines; the link clock must far
    // outrun the bus clock so that each fast mode phase holds samples
    assign sclRise = scl & ~lr.sclD;  // see RL4
    assign sclFall = ~scl & lr.sclD;
    assign startCond = scl & lr.sclD & ~sda & lr.sdaD;  // see RL8
    assign stopCond = scl & lr.sclD & sda & ~lr.sdaD;  // see RL11
    assign own7 = OWN7_BASE + {5'h00, linkSel};  // see RL18
    assign tenLo = TEN_LO_BASE + {5'h00, linkSel, 1'b0};

    // queue one register or general call request toward the core clock
    function automatic lnk_t issue(input lnk_t s, input isl_kind_t k,
                                   input logic [7:0] d);
        lnk_t o;
        o = s;
        if (!srcBusy)
        begin
            o.reqStb = 1'b1;
            o.req.kind = k;
            o.req.addr = s.regAddr;
            o.req.data = d;
        end
        // other addresses hold, such as a streaming port
        if ((k == K_WRITE || k == K_READ) && islAutoInc(s.regAddr))
            o.regAddr = s.regAddr + 8'h01;  // see RL2 RL3
        return o;
    endfunction : issue

    function automatic lnk_t ackByte(input lnk_t s);
        lnk_t o;
        o = s;
        o.sdaOe = 1'b1;  // see RL14
        o.slvAck = 1'b1;
        return o;
    endfunction : ackByte

    ////////////////////////////////////////////////////////////////////////////
    // link domain protocol engine
    always_comb
    begin
        ln = lr;
        ln.sclD = scl;
        ln.sdaD = sda;
        ln.reqStb = 1'b0;
        ln.sdaO = 1'b0;
        if (srcDone)
            ln.rdByte = srcRsp;
        if (startCond || stopCond)
        begin
            // a repeated start keeps the register pointer and 10-bit match
            ln.st = startCond ? ST_ADDR : ST_IDLE;  // see RL11 RL12 RL13
            ln.cnt = '0;
            ln.sdaOe = 1'b0;
            ln.slvAck = 1'b0;
            ln.tenOk = lr.tenOk & startCond;
        end
        else if (lr.st != ST_IDLE)  // see RL9
        begin
            if (sclRise)
            begin
                if (lr.cnt < BIT_ACK)
                begin
                    ln.sh = {lr.sh[6:0], sda};  // see RL16 RL25
                    ln.cnt = lr.cnt + 4'h1;
                end
                else if (lr.cnt == BIT_ACK)
                begin
                    ln.cnt = BIT_END;
                    if (lr.st == ST_RDATA && !lr.slvAck)
                    begin
                        if (!sda)
                            ln = issue(ln, K_READ, 8'h00);
                        else
                            ln.st = ST_IGNORE;  // see RL12
                    end
                end
            end
            else if (sclFall)
            begin
                if (lr.cnt == BIT_ACK)
                begin
                    case (lr.st)
                        ST_ADDR:
                        begin
                            if (lr.sh == GC_ADDR)
                            begin
                                ln = ackByte(ln);  // see RL24 RL5
                                ln.st = ST_GC;
                            end
                            else if (lr.sh[7:1] == own7)
                            begin
                                ln = ackByte(ln);  // see RL20
                                if (lr.sh[0])  // see RL19
                                begin
                                    ln.st = ST_RDATA;
                                    ln = issue(ln, K_READ, 8'h00);
                                end
                                else
                                    ln.st = ST_REG;
                            end
                            else if (lr.sh[7:3] == TEN_PREFIX &&
                                     lr.sh[2:1] == TEN_HI_BITS)
                            begin
                                if (!lr.sh[0])
                                begin
                                    ln = ackByte(ln);  // see RL5
                                    ln.st = ST_ADDR2;
                                end
                                else if (lr.tenOk)
                                begin
                                    ln = ackByte(ln);
                                    ln.st = ST_RDATA;
                                    ln = issue(ln, K_READ, 8'h00);
                                end
                                else
                                    ln.st = ST_IGNORE;
                            end
                            else
                                ln.st = ST_IGNORE;  // see RL21 RL15
                        end
                        ST_ADDR2:
                        begin
                            if (lr.sh == tenLo)
                            begin
                                ln = ackByte(ln);
                                ln.tenOk = 1'b1;
                                ln.st = ST_REG;
                            end
                            else
                                ln.st = ST_IGNORE;  // see RL21
                        end
                        ST_REG:
                        begin
                            ln = ackByte(ln);
                            ln.regAddr = lr.sh;
                            ln.st = ST_WDATA;
                        end
                        ST_WDATA:
                        begin
                            ln = ackByte(ln);
                            ln = issue(ln, K_WRITE, lr.sh);  // see RL1
                        end
                        ST_GC:
                        begin
                            // only the two latch codes are answered
                            if (lr.sh == GC_RESET_CODE ||  // see RL24
                                lr.sh == GC_LATCH_CODE)
                            begin
                                ln = ackByte(ln);
                                ln = issue(ln, lr.sh == GC_RESET_CODE ?
                                           K_RESET : K_LATCH, lr.sh);
                            end
                            ln.st = ST_IGNORE;
                        end
                        default:
                            ln.sdaOe = 1'b0;  // see RL14
                    endcase
                end
                else if (lr.cnt == BIT_END)
                begin
                    ln.sdaOe = 1'b0;
                    ln.slvAck = 1'b0;
                    ln.cnt = '0;
                    if (lr.st == ST_RDATA)
                    begin
                        ln.tx = lr.rdByte;
                        ln.sdaOe = ~lr.rdByte[7];  // see RL25
                    end
                end
                else if (lr.cnt != 4'h0 && lr.st == ST_RDATA)
                begin
                    ln.tx = {lr.tx[6:0], 1'b0};
                    ln.sdaOe = ~lr.tx[6];
                end
            end
        end
    end

    always_ff @(posedge linkSampleClk or negedge nrst)
    begin
        if (!nrst)
        begin
            lr <= '0;
            lr.regAddr <= REG_ADDR_RST;
            lr.sclD <= 1'b1;
            lr.sdaD <= 1'b1;
        end
        else
            lr <= ln;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: register port and address strap
    always_comb
    begin
        rn = rr;
        rn.port.wrStb = 1'b0;
        rn.port.rdStb = 1'b0;
        rn.ack = 1'b0;
        rn.softRst = 1'b0;
        if (!rr.strapDone && rr.settle == STRAP_SETTLE_CYC)
        begin
            rn.sel = pinSel;  // see RL6 RL7
            rn.strapDone = 1'b1;
        end
        else if (!rr.strapDone)
            rn.settle = rr.settle + 2'h1;
        if (rr.rdWait)
        begin
            rn.rsp = regRdData;
            rn.ack = 1'b1;
            rn.rdWait = 1'b0;
        end
        if (dstValid)
        begin
            case (dstReq.kind)
                K_WRITE:
                begin
                    rn.port.wrStb = 1'b1;  // see RL13
                    rn.port.addr = dstReq.addr;
                    rn.port.data = dstReq.data;
                    rn.ack = 1'b1;
                end
                K_READ:
                begin
                    rn.port.rdStb = 1'b1;
                    rn.port.addr = dstReq.addr;
                    rn.rdWait = 1'b1;
                end
                default:
                begin
                    rn.sel = pinSel;  // see RL7 RL24
                    rn.softRst = (dstReq.kind == K_RESET);
                    rn.ack = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rr <= '0;
        else
            rr <= rn;
    end
    assign sdaOut = lr.sdaO;
    assign sdaOe = lr.sdaOe;
    assign regPort = rr.port;
    assign gcSoftReset = rr.softRst;
    assign slaveAddrSel = rr.sel;
endmodule : isl_slave

/* File: isl_host_model.sv */
// behavioural bus master for the two-wire slave port
`timescale 1ns/100ps
module isl_host_model (
    input wire logic ref_clk,
    input wire logic sdaWire,
    output logic scl,
    output logic sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // quarter bit of 200 ns keeps the bus far below the link sampling rate
    task automatic q();
        repeat (20) @(posedge ref_clk);
    endtask : q
    // data moves only with the clock low, sampled mid high phase
    task automatic clk(input logic v, output logic s);
        sda <= v;
        q();
        scl <= 1'b1;
        q();
        s = sdaWire;
        q();
        scl <= 1'b0;
        q();
    endtask : clk
    // also a repeated start: data rises while the clock is still low
    task automatic start();
        sda <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask : start
    task automatic stop();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk(d[i], s);
        clk(1'b1, s);
        ack = !s;
    endtask : put
    task automatic get(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk(1'b1, d[i]);
        clk(!ackIt, s);
    endtask : get
endmodule : isl_host_model

/* File: isl_slave_properties.sv */
// concurrent checks on the ports of the two-wire slave port
`timescale 1ns/100ps
module isl_slave_properties (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic linkSampleClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic addrSelPinLow,
    input wire logic addrSelPinHigh,
    input wire isl_pkg::isl_regport_t regPort,
    input wire logic [7:0] regRdData,
    input wire logic gcSoftReset,
    input wire logic [1:0] slaveAddrSel
);
    import isl_pkg::*;
    logic sclPrev_r;
    logic [3:0] sinceFall_r;
    // link clocks since the bus clock fell, saturating
    always_ff @(posedge linkSampleClk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclPrev_r <= 1'b1;
            sinceFall_r <= 4'hf;
        end
        else
        begin
            sclPrev_r <= sclIn;
            if (sclPrev_r && !sclIn)
                sinceFall_r <= 4'h0;
            else if (sinceFall_r != 4'hf)
                sinceFall_r <= sinceFall_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_sda_open_drain:
        assert property (@(posedge linkSampleClk) disable iff (!nrst)
            sdaOe |-> sdaOut == 1'b0) else $error("data driven high");
    a_oe_after_fall:
        assert property (@(posedge linkSampleClk) disable iff (!nrst)
            $changed(sdaOe) |-> sinceFall_r inside {[4'h1:4'h6]})
            else $error("data drive moved outside clock low");
    a_stop_release:
        assert property (@(posedge linkSampleClk) disable iff (!nrst)
            sclIn && $rose(sdaIn) |=> !sdaOe [*8])
            else $error("data driven after stop");
    a_wr_single:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            regPort.wrStb |=> !regPort.wrStb) else $error("long write");
    a_rd_single:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            regPort.rdStb |=> !regPort.rdStb) else $error("long read");
    a_one_request:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            !(regPort.wrStb && regPort.rdStb)) else $error("read and write");
    a_gc_single:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            gcSoftReset |=> !gcSoftReset [*8]) else $error("reset pulse");
    a_gc_latch:
        assert property (@(posedge ref_clk) disable iff (!nrst)
            gcSoftReset |-> ##[0:8]
            slaveAddrSel == {addrSelPinHigh, addrSelPinLow})
            else $error("select not latched on reset call");
    c_write: cover property (@(posedge ref_clk) regPort.wrStb);
    c_read: cover property (@(posedge ref_clk) regPort.rdStb);
    c_gc: cover property (@(posedge ref_clk) gcSoftReset);
endmodule : isl_slave_properties

bind isl_slave isl_slave_properties u_props (.ref_clk(ref_clk),
    .nrst(nrst), .linkSampleClk(linkSampleClk), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelPinLow(addrSelPinLow), .addrSelPinHigh(addrSelPinHigh),
    .regPort(regPort), .regRdData(regRdData), .gcSoftReset(gcSoftReset),
    .slaveAddrSel(slaveAddrSel));

/* File: isl_slave_tb.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/100ps
module isl_slave_tb;
    import isl_pkg::*;
    logic ref_clk, linkClk, nrst, scl, sda, sdaOut, sdaOe, gcSoftReset;
    logic pinLo, pinHi, ack;
    logic [1:0] slaveAddrSel;
    logic [7:0] regRdData, rd;
    isl_regport_t regPort;
    int miscompares = 0, checked = 0, gcCnt = 0;
    logic [15:0] wrQ[$];
    wire logic sdaWire = sda & !sdaOe;
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        linkClk = 1'b0;
        #3.3;
        forever #6 linkClk = ~linkClk;
    end
    // register file stand-in: read data derived from the address
    assign regRdData = regPort.addr ^ 8'h5a;
    always @(posedge ref_clk)
    begin
        if (regPort.wrStb === 1'b1)
            wrQ.push_back({regPort.addr, regPort.data});
        if (gcSoftReset === 1'b1)
            gcCnt++;
    end
    isl_slave dut (.ref_clk(ref_clk), .nrst(nrst), .linkSampleClk(linkClk),
        .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSelPinLow(pinLo), .addrSelPinHigh(pinHi), .regPort(regPort),
        .regRdData(regRdData), .gcSoftReset(gcSoftReset),
        .slaveAddrSel(slaveAddrSel));
    isl_host_model host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl),
        .sda(sda));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // two data bytes after one register address byte, stores awaited and compared with r and r2
    task automatic wr_two(input logic [7:0] r, input logic [7:0] r2);
        wrQ.delete();
        host.start();
        host.put(8'h88, ack);
        check("addr ack", ack, 1'b1);
        host.put(r, ack);
        host.put(8'h11, ack);
        host.put(8'h22, ack);
        check("data ack", ack, 1'b1);
        host.stop();
        for (int i = 0; i < 200 && wrQ.size() < 2; i++)
            @(posedge ref_clk);
        repeat (200) @(posedge ref_clk);
        check("store 0", wrQ[0], {r, 8'h11});
        check("store 1", wrQ[1], {r2, 8'h22});
        check("no more", 16'(wrQ.size()), 16'h0002);
    endtask : wr_two
    task automatic t_write();
        check("strap", slaveAddrSel, 2'b10);
        wr_two(8'h07, 8'h08);
        wr_two(8'h38, 8'h38);
        $display("test write done");
    endtask : t_write
    task automatic t_read();
        host.start();
        host.put(8'h88, ack);
        host.put(8'h10, ack);
        host.start();
        host.put(8'h89, ack);
        check("read ack", ack, 1'b1);
        host.get(1'b1, rd);
        check("read 0", rd, 8'h10 ^ 8'h5a);
        host.get(1'b0, rd);
        check("read 1", rd, 8'h11 ^ 8'h5a);
        host.stop();
        check("released", sdaOe, 1'b0);
        $display("test read done");
    endtask : t_read
    task automatic t_nomatch();
        wrQ.delete();
        host.start();
        host.put(8'h84, ack);
        check("foreign ack", ack, 1'b0);
        host.put(8'h00, ack);
        check("foreign byte", ack, 1'b0);
        host.stop();
        host.put(8'h88, ack);
        check("no start", ack, 1'b0);
        host.stop();
        check("no store", 16'(wrQ.size()), 16'h0000);
        $display("test nomatch done");
    endtask : t_nomatch
    task automatic t_ten();
        wrQ.delete();
        host.start();
        host.put({TEN_PREFIX, TEN_HI_DEF, 1'b0}, ack);
        check("ten hdr", ack, 1'b1);
        host.put(TEN_LO_DEF + 8'h04, ack);
        check("ten low", ack, 1'b1);
        host.put(8'h60, ack);
        host.put(8'h77, ack);
        host.stop();
        for (int i = 0; i < 200 && wrQ.size() < 1; i++)
            @(posedge ref_clk);
        check("ten store", wrQ[0], 16'h6077);
        $display("test ten done");
    endtask : t_ten
    task automatic gc(input logic [7:0] code, input logic expAck);
        host.start();
        host.put(GC_ADDR, ack);
        check("gc ack", ack, 1'b1);
        host.put(code, ack);
        check("gc code", ack, expAck);
        host.stop();
        repeat (200) @(posedge ref_clk);
    endtask : gc
    task automatic t_gc();
        pinLo <= 1'b1;
        pinHi <= 1'b0;
        repeat (200) @(posedge ref_clk);
        check("strap kept", slaveAddrSel, 2'b10);
        gc(8'h04, 1'b1);
        check("latched", slaveAddrSel, 2'b01);
        check("no reset", 16'(gcCnt), 16'h0000);
        gc(8'h06, 1'b1);
        check("reset", 16'(gcCnt), 16'h0001);
        gc(8'h00, 1'b0);
        $display("test gc done");
    endtask : t_gc
    initial
    begin
        nrst = 1'b0;
        pinLo = 1'b0;
        pinHi = 1'b1;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (100) @(posedge ref_clk);
        t_write();
        t_read();
        t_nomatch();
        t_ten();
        t_gc();
        test_done();
    end
    initial
    begin
        repeat (80000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end
endmodule : isl_slave_tb
